// ---- src/flash_host.sv ----
// APB-controlled host that runs command sequences on a parallel NOR flash
`timescale 1ns/1ps
module flash_host
	import flash_host_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Flash pins
	output logic             ce_n_o,
	output logic             oe_n_o,
	output logic             we_n_o,
	output logic             byte_n_o,
	output logic             hw_reset_n_o,
	output logic             high_voltage_level_o,
	output logic [19:0]      addr_o,
	output logic [15:0]      dq_o,
	output logic             dq_oe_n_o,
	input  wire logic [15:0] dq_i,
	input  wire logic        ready_busy_n_i
);
	import flash_host_pkg::*;

	typedef enum {H_IDLE, H_ISSUE, H_WAIT, H_POLL, H_HWRST, H_DONE} hst_t;

	flash_cyc_if cif ();

	logic [31:0] ctrl_q;
	logic [19:0] addr_q;
	logic [15:0] wdata_q;
	logic [15:0] rdata_q;
	logic        tout_q;
	logic        hv_q;
	logic        busy_q;
	logic        req_q;
	cycle_t      cyc_q;
	logic [2:0]  step_q;
	logic [7:0]  cnt_q;
	logic        hwrst_n_q;
	logic        byte_n_q;
	logic [15:0] prev_q;
	logic        poll_first_q;
	logic        tout_pend_q;
	hst_t        st_q;

	wire         apb_acc = psel_i && penable_i;
	wire         apb_wr = apb_acc && pwrite_i;
	wire         go_wr = apb_wr && (paddr_i == CTRL_OFF) && pwdata_i[GO_BIT] && !busy_q;
	wire         go_hw = op_t'(pwdata_i[CMD_LSB +: CMD_W]) == OP_HW_RESET;
	wire         hit = (paddr_i == CTRL_OFF) || (paddr_i == ADDR_OFF) || (paddr_i == WDATA_OFF) ||
	                   (paddr_i == STAT_OFF) || (paddr_i == RDATA_OFF) || (paddr_i == PINS_OFF);
	wire op_t    op = op_t'(ctrl_q[CMD_LSB +: CMD_W]);
	wire         byte_mode = ctrl_q[BYTE_MODE_BIT];
	// In byte mode the unlock addresses shift up by one bit
	wire [19:0]  ul1 = byte_mode ? {8'h00, UNLOCK1_ADDR, 1'b0} : {9'h000, UNLOCK1_ADDR};
	wire [19:0]  ul2 = byte_mode ? {8'h00, UNLOCK2_ADDR, 1'b0} : {9'h000, UNLOCK2_ADDR};
	wire         unlock_step = (step_q < 3'd2);
	wire [2:0]   last_step = (op == OP_PROGRAM) ? 3'd3 : (op == OP_IDENT) ? 3'd2 : 3'd0;
	// Toggle bit steady across two reads means the algorithm finished
	wire         toggling = prev_q[TOGGLE_POS] != cif.rdata[TOGGLE_POS];
	wire         tout_seen = cif.rdata[TOUT_POS] && toggling;

	assign cif.req = req_q;
	assign cif.cyc = cyc_q;

	flash_bus_cycle u_cyc (
		.clk_i     (clk_i),
		.reset_i   (reset_i),
		.c         (cif),
		.ce_n_o    (ce_n_o),
		.oe_n_o    (oe_n_o),
		.we_n_o    (we_n_o),
		.addr_o    (addr_o),
		.dq_o      (dq_o),
		.dq_oe_n_o (dq_oe_n_o),
		.dq_i      (dq_i)
	);

	// Register file
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			ctrl_q <= CTRL_RESET;
			addr_q <= 20'h00000;
			wdata_q <= 16'h0000;
			hv_q <= 1'b0;
			prdata_o <= 32'h0000_0000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
		else
		begin
			pready_o <= psel_i && !pready_o;
			pslverr_o <= psel_i && !pready_o && !hit;
			if (apb_wr && pready_o)
			begin
				if (paddr_i == CTRL_OFF && !busy_q)
					ctrl_q <= {23'h0, 1'b0, 3'h0, pwdata_i[BYTE_MODE_BIT], 1'b0, pwdata_i[CMD_LSB +: CMD_W]};
				if (paddr_i == ADDR_OFF)
					addr_q <= pwdata_i[19:0];
				if (paddr_i == WDATA_OFF)
					wdata_q <= pwdata_i[15:0];
				// Temporary unprotect while the high level is driven
				// No permanent unprotect write is ever issued, so no protect-all pass is owed
				if (paddr_i == PINS_OFF)
					hv_q <= pwdata_i[0];
			end
			case (paddr_i)
				CTRL_OFF:  prdata_o <= ctrl_q;
				ADDR_OFF:  prdata_o <= {12'h000, addr_q};
				WDATA_OFF: prdata_o <= {16'h0000, wdata_q};
				STAT_OFF:  prdata_o <= {29'h0, ready_busy_n_i, tout_q, busy_q};
				RDATA_OFF: prdata_o <= {16'h0000, rdata_q};
				PINS_OFF:  prdata_o <= {31'h0, hv_q};
				default:   prdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// Sequencer
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			st_q <= H_IDLE;
			busy_q <= 1'b0;
			tout_q <= 1'b0;
			req_q <= 1'b0;
			cyc_q <= '0;
			step_q <= 3'd0;
			cnt_q <= 8'h00;
			rdata_q <= 16'h0000;
			prev_q <= 16'h0000;
			poll_first_q <= 1'b0;
			tout_pend_q <= 1'b0;
			hwrst_n_q <= 1'b1;
			byte_n_q <= 1'b1;
			high_voltage_level_o <= 1'b0;
		end
		else
		begin
			high_voltage_level_o <= hv_q;
			case (st_q)
				H_IDLE:
					if (go_wr && pready_o)
					begin
						busy_q <= 1'b1;
						step_q <= 3'd0;
						// Width select follows the requested mode
						byte_n_q <= !pwdata_i[BYTE_MODE_BIT];
						st_q <= go_hw ? H_HWRST : H_ISSUE;
						// Reset register drops at the go edge, the pin one clock later, so the pin's low time is the full count
						hwrst_n_q <= !go_hw;
						cnt_q <= 8'(HWRST_CYC);
					end
				H_ISSUE:
				begin
					req_q <= 1'b1;
					cyc_q.write <= (op != OP_READ);
					case (op)
						OP_READ:      cyc_q <= '{addr: addr_q, data: 16'h0000, write: 1'b0};
						// Single write, any address, returns to array read
						OP_RESET:     cyc_q <= '{addr: addr_q, data: {8'h00, CMD_RESET_CODE}, write: 1'b1};
						OP_RAW_WRITE: cyc_q <= '{addr: addr_q, data: wdata_q, write: 1'b1};
						default:
							// Two unlocks, then command, then target for program
							if (unlock_step)
								cyc_q <= '{addr: (step_q == 3'd0) ? ul1 : ul2,
								           data: {8'h00, (step_q == 3'd0) ? UNLOCK1_DATA : UNLOCK2_DATA}, write: 1'b1};
							else if (step_q == 3'd2)
								cyc_q <= '{addr: ul1, data: {8'h00, (op == OP_IDENT) ? CMD_ID_CODE : CMD_PROG_CODE},
								           write: 1'b1};
							else
								cyc_q <= '{addr: addr_q, data: wdata_q, write: 1'b1};
					endcase
					st_q <= H_WAIT;
				end
				H_WAIT:
					if (cif.done)
					begin
						req_q <= 1'b0;
						rdata_q <= cif.rdata;
						if (step_q < last_step)
						begin
							step_q <= step_q + 3'd1;
							st_q <= H_ISSUE;
						end
						else if (op == OP_PROGRAM)
						begin
							// Poll status; no commands issued while it runs
							prev_q <= cif.rdata;
							// The write cycle's sample is no status word, so the first poll only primes
							poll_first_q <= 1'b1;
							tout_pend_q <= 1'b0;
							cyc_q <= '{addr: addr_q, data: 16'h0000, write: 1'b0};
							req_q <= 1'b1;
							st_q <= H_POLL;
						end
						else
							st_q <= H_DONE;
					end
				H_POLL:
					if (cif.done)
					begin
						prev_q <= cif.rdata;
						rdata_q <= cif.rdata;
						poll_first_q <= 1'b0;
						tout_pend_q <= tout_seen && !poll_first_q;
						// Bit 5 counts only if the toggle still runs on the read after it
						if (!poll_first_q && (!toggling || (tout_seen && tout_pend_q)))
						begin
							req_q <= 1'b0;
							// Timeout flag left for software, which then issues reset
							tout_q <= toggling;
							st_q <= H_DONE;
						end
					end
				H_HWRST:
				begin
					// Hardware reset pulse aborts running program
					if (cnt_q > 8'h01)
						cnt_q <= cnt_q - 8'h01;
					else
					begin
						hwrst_n_q <= 1'b1;
						st_q <= H_DONE;
					end
				end
				H_DONE:
				begin
					busy_q <= 1'b0;
					st_q <= H_IDLE;
				end
				default:
					st_q <= H_IDLE;
			endcase
			if (go_wr && pready_o)
				tout_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			hw_reset_n_o <= 1'b1;
			byte_n_o <= 1'b1;
		end
		else
		begin
			hw_reset_n_o <= hwrst_n_q;
			byte_n_o <= byte_n_q;
		end
	end
endmodule

// ---- src/flash_host_pkg.sv ----
// Constants and types for the parallel NOR flash host controller
//
// Function
// - Write only with chip select, strobe low
// - Identification mode left only by reset
// - Host resets after timeout error bit; this host only sets the timeout flag and leaves the reset to software
// - Two unlocks plus identification command enter
// - Program uses four write cycles
// - Hardware reset kills program; host repeats; this host does not reissue the program
// - Protect all sectors before unprotect writes
package flash_host_pkg;

	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned STROBE_NS = 100;
	localparam int unsigned STROBE_CYC = (STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned HWRST_NS = 500;
	localparam int unsigned HWRST_CYC = (HWRST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	// Register byte offsets on the APB slave
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] ADDR_OFF = 8'h04;
	localparam logic [7:0] WDATA_OFF = 8'h08;
	localparam logic [7:0] STAT_OFF = 8'h0c;
	localparam logic [7:0] RDATA_OFF = 8'h10;
	localparam logic [7:0] PINS_OFF = 8'h14;

	// Control register fields
	localparam int unsigned CMD_LSB = 0;
	localparam int unsigned CMD_W = 3;
	localparam int unsigned BYTE_MODE_BIT = 4;
	localparam int unsigned GO_BIT = 8;

	// Status register fields
	localparam int unsigned BUSY_BIT = 0;
	localparam int unsigned TOUT_BIT = 1;
	localparam int unsigned RB_BIT = 2;

	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Unlock addresses and data, command codes
	localparam logic [10:0] UNLOCK1_ADDR = 11'h555;
	localparam logic [10:0] UNLOCK2_ADDR = 11'h2aa;
	localparam logic [7:0] UNLOCK1_DATA = 8'haa;
	localparam logic [7:0] UNLOCK2_DATA = 8'h55;
	localparam logic [7:0] CMD_RESET_CODE = 8'hf0;
	localparam logic [7:0] CMD_ID_CODE = 8'h90;
	localparam logic [7:0] CMD_PROG_CODE = 8'ha0;

	// Status bit positions on the data bus
	localparam int unsigned POLL_POS = 7;
	localparam int unsigned TOGGLE_POS = 6;
	localparam int unsigned TOUT_POS = 5;

	typedef enum logic [2:0] {
		OP_READ,
		OP_RESET,
		OP_IDENT,
		OP_PROGRAM,
		OP_RAW_WRITE,
		OP_HW_RESET
	} op_t;

	typedef struct packed {
		logic [19:0] addr;
		logic [15:0] data;
		logic        write;
	} cycle_t;

endpackage

// ---- src/flash_cyc_if.sv ----
// Handshake between the sequencer and the bus cycle engine
`timescale 1ns/1ps
interface flash_cyc_if;
	import flash_host_pkg::*;
	logic   req;
	cycle_t cyc;
	logic   done;
	logic [15:0] rdata;
	modport seq (output req, output cyc, input done, input rdata);
	modport eng (input req, input cyc, output done, output rdata);
endinterface

// ---- src/flash_bus_cycle.sv ----
// One asynchronous read or write cycle on the flash pins
`timescale 1ns/1ps
module flash_bus_cycle
	import flash_host_pkg::*;
(
	// Clock and reset
	input  wire logic   clk_i,
	input  wire logic   reset_i,
	// Sequencer side
	flash_cyc_if.eng    c,
	// Pins
	output logic        ce_n_o,
	output logic        oe_n_o,
	output logic        we_n_o,
	output logic [19:0] addr_o,
	output logic [15:0] dq_o,
	output logic        dq_oe_n_o,
	input  wire logic [15:0] dq_i
);
	typedef enum {S_IDLE, S_SETUP, S_STROBE, S_HOLD} cst_t;
	cst_t        st_q;
	logic [7:0]  cnt_q;
	logic        done_q;
	logic [15:0] rdata_q;

	assign c.done = done_q;
	assign c.rdata = rdata_q;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			st_q <= S_IDLE;
			cnt_q <= 8'h00;
			done_q <= 1'b0;
			rdata_q <= 16'h0000;
			ce_n_o <= 1'b1;
			oe_n_o <= 1'b1;
			we_n_o <= 1'b1;
			addr_o <= 20'h00000;
			dq_o <= 16'h0000;
			dq_oe_n_o <= 1'b1;
		end
		else
		begin
			done_q <= 1'b0;
			case (st_q)
				S_IDLE:
					if (c.req && !done_q)
					begin
						// Address settles before any strobe falls, so the late-falling latch sees it
						addr_o <= c.cyc.addr;
						dq_o <= c.cyc.data;
						dq_oe_n_o <= !c.cyc.write;
						ce_n_o <= 1'b0;
						st_q <= S_SETUP;
					end
				S_SETUP:
				begin
					// Write asserts only with output enable high
					we_n_o <= !c.cyc.write;
					oe_n_o <= c.cyc.write;
					cnt_q <= 8'(STROBE_CYC);
					st_q <= S_STROBE;
				end
				S_STROBE:
					if (cnt_q > 8'h01)
						cnt_q <= cnt_q - 8'h01;
					else
					begin
						rdata_q <= dq_i;
						// Strobe rises first, data still driven for the early-rising latch
						we_n_o <= 1'b1;
						oe_n_o <= 1'b1;
						st_q <= S_HOLD;
					end
				S_HOLD:
				begin
					ce_n_o <= 1'b1;
					dq_oe_n_o <= 1'b1;
					done_q <= 1'b1;
					st_q <= S_IDLE;
				end
				default:
					st_q <= S_IDLE;
			endcase
		end
	end
endmodule

// ---- verification/flash_host_props.sv ----
// Checker for the flash host pins and APB answer
`timescale 1ns/1ps
module flash_host_props (
	input wire logic        clk_i, reset_i, psel_i, penable_i, pready_o, pslverr_o,
	input wire logic        ce_n_o, oe_n_o, we_n_o, hw_reset_n_o, dq_oe_n_o,
	input wire logic [19:0] addr_o,
	input wire logic [15:0] dq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	write_qual_a: assert property (!we_n_o |-> !ce_n_o && oe_n_o)
		else $error("write strobe not qualified");
	no_fight_a: assert property (!oe_n_o |-> dq_oe_n_o)
		else $error("data driven during read");
	select_first_a: assert property ($fell(we_n_o) |-> $past(!ce_n_o))
		else $error("strobe fell before select");
	strobe_width_a: assert property ($fell(we_n_o) |-> !we_n_o ##1 !we_n_o ##1 we_n_o)
		else $error("write strobe width wrong");
	write_hold_a: assert property (!we_n_o || $rose(we_n_o) |-> !dq_oe_n_o && $stable(addr_o) && $stable(dq_o))
		else $error("address or data moved in strobe");
	hw_width_a: assert property ($fell(hw_reset_n_o) |-> ##9 !hw_reset_n_o ##1 hw_reset_n_o)
		else $error("hardware reset width wrong");
	apb_answer_a: assert property (psel_i && !penable_i |-> ##[1:2] pready_o)
		else $error("no answer in time");
	err_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	cover property ($fell(we_n_o));
	cover property ($fell(oe_n_o));
	cover property ($fell(hw_reset_n_o));
	cover property (pslverr_o);
endmodule

bind flash_host flash_host_props u_props (.*);

// ---- verification/flash_model.sv ----
// Behavioural parallel NOR flash on the host's pins
`timescale 1ns/1ps
module flash_model
	import flash_host_pkg::*;
#(
	parameter logic [15:0] MAKER   = 16'h00a5, // Arbitrary value
	parameter logic [15:0] PART    = 16'h005a, // Arbitrary value
	parameter int          PROG_NS = 2000
)(
	input  wire logic        ce_n_i, oe_n_i, we_n_i, hw_reset_n_i, hv_i,
	input  wire logic [19:0] addr_i,
	input  wire logic [15:0] dq_i,
	output logic [15:0]      dq_o,
	output logic             ready_busy_n_o
);
	logic [15:0] mem [logic [19:0]];
	logic [19:0] la;
	logic [15:0] last = 16'h0000, pd;
	logic        busy = 1'b0, tog = 1'b0;
	int          st = 0; // Power-up in array read
	initial dq_o = 16'hffff;
	assign ready_busy_n_o = !busy;
	function automatic logic [15:0] rd(input logic [19:0] a);
		return mem.exists(a) ? mem[a] : 16'hffff;
	endfunction
	// Only 10000h-1ffffh is protected
	function automatic logic prot(input logic [19:0] a);
		return a[19:16] == 4'h1;
	endfunction
	task automatic prog(input logic [19:0] a, input logic [15:0] d);
		busy = 1'b1;
		pd = d;
		repeat (PROG_NS / 50) if (hw_reset_n_i) #50;
		if (hw_reset_n_i) mem[a] = rd(a) & d;
		busy = 1'b0;
	endtask
	always @(negedge hw_reset_n_i) st = 0;
	always @(negedge we_n_i) if (!ce_n_i && oe_n_i) la = addr_i;
	always @(posedge we_n_i)
		if (!ce_n_i && oe_n_i && hw_reset_n_i && !busy)
			if (dq_i[7:0] == CMD_RESET_CODE) st = 0;
			else case (st)
			0: st = int'(la[10:0] == UNLOCK1_ADDR && dq_i[7:0] == UNLOCK1_DATA);
			1: st = la[10:0] == UNLOCK2_ADDR && dq_i[7:0] == UNLOCK2_DATA ? 2 : 0;
			2: st = la[10:0] != UNLOCK1_ADDR ? 0 : dq_i[7:0] == CMD_ID_CODE ? 3 :
				dq_i[7:0] == CMD_PROG_CODE ? 4 : 0;
			4:
			begin
				st = 0;
				if (!prot(la) || hv_i) prog(la, dq_i);
			end
			default: ; // Identification holds until reset
			endcase
	always @(negedge oe_n_i)
		if (!ce_n_i)
		begin
			tog = tog ^ busy;
			if (busy) last = {8'h00, ~pd[7], tog, 6'h00};
			else if (st == 3) last = addr_i[7:0] == 8'h00 ? MAKER :
				addr_i[7:0] == 8'h01 ? PART : {15'h0000, prot(addr_i)};
			else last = rd(addr_i); // No erase suspend here, so array data everywhere
			dq_o = last;
		end
	// A released bus must not keep showing the last word
	always @(posedge oe_n_i) dq_o = ~last;
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench: APB host driving the flash model
`timescale 1ns/1ps
module tb_top;
	import flash_host_pkg::*;
	logic        clk_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [7:0]  paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, r;
	logic        pready_o, pslverr_o, ce_n_o, oe_n_o, we_n_o, byte_n_o, hw_reset_n_o, dq_oe_n_o;
	logic        high_voltage_level_o, ready_busy_n_i, slv;
	logic [19:0] addr_o;
	logic [15:0] dq_o, dq_i;
	int          n_mismatch = 0, check_count = 0, cyc = 0;
	always #25 clk_i = ~clk_i;
	flash_host u_dut (.*);
	flash_model u_mem (.ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o), .hw_reset_n_i(hw_reset_n_o),
		.hv_i(high_voltage_level_o), .addr_i(addr_o), .dq_i(dq_o), .dq_o(dq_i), .ready_busy_n_o(ready_busy_n_i));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1 && ++n < 50);
		r = prdata_o;
		slv = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic op(input op_t o, input logic [19:0] a, input logic [15:0] d);
		int n = 0;
		apb(1'b1, ADDR_OFF, {12'h000, a});
		apb(1'b1, WDATA_OFF, {16'h0000, d});
		apb(1'b1, CTRL_OFF, (32'h1 << GO_BIT) | 32'(o));
		do apb(1'b0, STAT_OFF, 32'h0); while (r[BUSY_BIT] !== 1'b0 && ++n < 500);
	endtask
	task automatic rdw(input logic [19:0] a, input logic [15:0] e);
		op(OP_READ, a, 16'h0000);
		apb(1'b0, RDATA_OFF, 32'h0);
		check(r, {16'h0000, e});
	endtask
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			n_mismatch++;
			complete_run();
		end
	end
	initial
	begin
		repeat (10) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		apb(1'b0, CTRL_OFF, 32'h0);
		check(r, CTRL_RESET);
		apb(1'b0, 8'h3c, 32'h0);
		check({r[30:0], slv}, 32'h1);
		rdw(20'h00100, 16'hffff);
		op(OP_IDENT, 20'h00000, 16'h0000);
		rdw(20'h00000, u_mem.MAKER);
		rdw(20'h00001, u_mem.PART);
		rdw(20'h10002, 16'h0001);
		rdw(20'h20002, 16'h0000);
		rdw(20'h00000, u_mem.MAKER);
		op(OP_RESET, 20'h54321, 16'h0000);
		rdw(20'h00000, 16'hffff);
		apb(1'b1, CTRL_OFF, (32'h1 << GO_BIT) | (32'h1 << BYTE_MODE_BIT) | 32'(OP_RESET));
		apb(1'b0, CTRL_OFF, 32'h0);
		check(r, 32'h0000_0011);
		check({31'h0, byte_n_o}, 32'h0);
		do apb(1'b0, STAT_OFF, 32'h0); while (r[BUSY_BIT] !== 1'b0);
		op(OP_PROGRAM, 20'h00100, 16'h1234);
		check({29'h0, r[2:0]}, 32'h4);
		rdw(20'h00100, 16'h1234);
		op(OP_PROGRAM, 20'h00100, 16'hff0f);
		rdw(20'h00100, 16'h1204);
		op(OP_PROGRAM, 20'h10005, 16'h0000);
		rdw(20'h10005, 16'hffff);
		apb(1'b1, PINS_OFF, 32'h1);
		@(posedge clk_i);
		check({31'h0, high_voltage_level_o}, 32'h1);
		op(OP_PROGRAM, 20'h10005, 16'h00aa);
		apb(1'b1, PINS_OFF, 32'h0);
		op(OP_PROGRAM, 20'h10005, 16'h0000);
		rdw(20'h10005, 16'h00aa);
		op(OP_RAW_WRITE, {9'h000, UNLOCK1_ADDR}, {8'h00, UNLOCK1_DATA});
		op(OP_RAW_WRITE, 20'h00123, {8'h00, UNLOCK2_DATA});
		op(OP_RAW_WRITE, {9'h000, UNLOCK1_ADDR}, {8'h00, CMD_ID_CODE});
		rdw(20'h00000, 16'hffff);
		op(OP_IDENT, 20'h00000, 16'h0000);
		op(OP_HW_RESET, 20'h00000, 16'h0000);
		rdw(20'h00000, 16'hffff);
		apb(1'b0, STAT_OFF, 32'h0);
		check({29'h0, r[2:0]}, 32'h4);
		complete_run();
	end
endmodule
